/* File: logic/dli_status.v */
// Link initiator control, acknowledge timeout and error status registers
//
// Behaviour
// R01 - Forward external interrupt only when enabled
// R02 - Software writes zero into control bits 6:4
// R03 - Count link cycles after last transfer, time out
// R04 - Timeout sets read-only wait expired flag
// R05 - Limit zero: acknowledge right after last transfer
// R06 - Nonzero limit allows that many wait cycles
// R07 - Wait limit write-once normally, free in special
// R08 - After enable, write-once bits ignore writes
// R09 - Summary flag set by any error flag
// R10 - Writing one clears summary, zero does nothing
// R11 - Acknowledge with low data line sets fault
// R12 - Pending error cancels requests, sends idle
// R13 - Target error in acknowledge sets fault
// R14 - Detected parity error sets parity fault
// R15 - Received parity bits shown in bits 1:0
// R16 - Error flags clear with the summary flag
// R17 - Enabled link drives idle lines and clock
// R18 - External interrupt pin level readable as flag
// R19 - Restart counter each transaction, stop at acknowledge
// R20 - Status resets to zero, summary sets together
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "dli_consts.vh"
module dli_status (
  input wire i_core_clk,
  input wire i_reset,
  input wire [`DLI_AXI_ADDR_W-1:0] i_s_axi_awaddr,
  input wire [2:0] i_s_axi_awprot,
  input wire i_s_axi_awvalid,
  output wire o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output wire o_s_axi_wready,
  output wire [1:0] o_s_axi_bresp,
  output wire o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [`DLI_AXI_ADDR_W-1:0] i_s_axi_araddr,
  input wire [2:0] i_s_axi_arprot,
  input wire i_s_axi_arvalid,
  output wire o_s_axi_arready,
  output wire [31:0] o_s_axi_rdata,
  output wire [1:0] o_s_axi_rresp,
  output wire o_s_axi_rvalid,
  input wire i_s_axi_rready,
  input wire i_special_mode,
  input wire i_ext_irq_pin,
  output wire o_ext_irq,
  output wire o_error_irq,
  input wire i_txn_request,
  output wire o_txn_grant,
  output wire o_txn_cancel,
  input wire i_last_xfer,
  input wire i_ack_strobe,
  input wire i_target_err,
  input wire i_parity_err,
  input wire i_parity_valid,
  input wire [1:0] i_parity_bits,
  input wire [7:0] i_link_data_in,
  output wire [7:0] o_link_data_lines,
  output wire [7:0] o_link_data_oe_n,
  output wire o_link_clock_out,
  output wire o_link_tick,
  output wire o_ack_waiting,
  output wire o_wait_expired
);

  localparam IDX_HI = `DLI_AXI_ADDR_W - 1;

  // Link control state
  reg initiator_enable_ff;
  reg width8_ff;
  reg [1:0] clk_div_ff;
  // Interrupt enable and wait limit
  reg ext_irq_enable_ff;
  reg [3:0] ack_wait_limit_ff;
  // Error status flags and the external interrupt pin flag
  reg error_summary_flag_ff;
  reg ack_level_fault_flag_ff;
  reg cancelled_flag_ff;
  reg wait_expired_flag_ff;
  reg target_fault_flag_ff;
  reg parity_fault_flag_ff;
  reg received_parity_hi_ff;
  reg received_parity_lo_ff;
  reg ext_irq_flag_ff;
  // Link clock divider
  reg [1:0] div_cnt_ff;
  reg link_clock_out_ff;
  reg [1:0] nxt_div_cnt;
  // Bus slave state
  reg aw_full_ff;
  reg [`DLI_AXI_ADDR_W-1:0] aw_addr_ff;
  reg w_full_ff;
  reg [7:0] w_data_ff;
  reg w_lane0_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;

  reg wr_hit_link;
  reg wr_hit_irq;
  reg wr_hit_stat;
  reg wr_map;
  reg [7:0] rd_val;
  reg rd_map;

  wire [`DLI_IDX_W-1:0] wr_idx;
  wire [`DLI_IDX_W-1:0] rd_idx;
  wire do_write;
  wire lane_write;
  wire wo_locked;
  wire status_clear;
  wire [7:0] used_mask;
  wire ack_fault_set;
  wire target_fault_set;
  wire cancel_set;
  wire expired_pulse;
  wire any_error_set;
  wire timer_waiting;

  // Write channel: address and data are held until both are present
  assign o_s_axi_awready = ~aw_full_ff & ~bvalid_ff;
  assign o_s_axi_wready = ~w_full_ff & ~bvalid_ff;
  assign do_write = aw_full_ff & w_full_ff & ~bvalid_ff;
  assign wr_idx = aw_addr_ff[IDX_HI:2];
  // Registers are eight bits wide, so only byte lane 0 carries a write
  assign lane_write = do_write & w_lane0_ff;
  // Once enabled in normal modes only a reset reopens the setup bits
  assign wo_locked = initiator_enable_ff & ~i_special_mode; // see R08

  // Write address decode
  always @* begin
    wr_hit_link = 1'b0;
    wr_hit_irq = 1'b0;
    wr_hit_stat = 1'b0;
    wr_map = 1'b1;
    if (wr_idx == `DLI_IDX_LINK_CTRL) begin
      wr_hit_link = 1'b1;
    end else if (wr_idx == `DLI_IDX_IRQ_TMO_CTRL) begin
      wr_hit_irq = 1'b1;
    end else if (wr_idx == `DLI_IDX_ERR_STAT) begin
      wr_hit_stat = 1'b1;
    end else if (wr_idx == `DLI_IDX_LINK_STAT) begin
      wr_map = 1'b1; // Read-only, write accepted without effect
    end else begin
      wr_map = 1'b0;
    end
  end

  // Write-one on the summary bit; zero leaves everything alone
  assign status_clear = lane_write & wr_hit_stat &
                        w_data_ff[`DLI_SUM_BIT]; // see R10

  // Bus write handshake and response
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      aw_full_ff <= 1'b0;
      aw_addr_ff <= {`DLI_AXI_ADDR_W{1'b0}};
      w_full_ff <= 1'b0;
      w_data_ff <= 8'h00;
      w_lane0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `DLI_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid & o_s_axi_awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid & o_s_axi_wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= i_s_axi_wdata[7:0];
        w_lane0_ff <= i_s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_map ? `DLI_RESP_OKAY : `DLI_RESP_SLVERR;
      end else if (bvalid_ff & i_s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign o_s_axi_bvalid = bvalid_ff;
  assign o_s_axi_bresp = bresp_ff;

  // Control registers; the interrupt enable stays writable at all times
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      initiator_enable_ff <= |(`DLI_LINK_CTRL_RST & (8'h01 << `DLI_EN_BIT));
      width8_ff <= 1'b0;
      clk_div_ff <= 2'b00;
      ext_irq_enable_ff <= 1'b0;
      ack_wait_limit_ff <= 4'h0;
    end else begin
      if (lane_write & wr_hit_link & ~wo_locked) begin // see R08
        initiator_enable_ff <= w_data_ff[`DLI_EN_BIT];
        width8_ff <= w_data_ff[`DLI_WIDTH8_BIT];
        clk_div_ff <= w_data_ff[`DLI_DIV_HI:`DLI_DIV_LO];
      end
      if (lane_write & wr_hit_irq) begin
        ext_irq_enable_ff <= w_data_ff[`DLI_IRQ_EN_BIT];
        // Bits 6:4 are not stored and read back as zero
        if (~wo_locked) begin // see R07
          ack_wait_limit_ff <= w_data_ff[`DLI_LIMIT_HI:`DLI_LIMIT_LO];
        end
      end
    end
  end

  // Divided link clock; high phase one core cycle per period, held high at divide by one
  always @* begin
    if (div_cnt_ff == clk_div_ff) begin
      nxt_div_cnt = 2'b00;
    end else begin
      nxt_div_cnt = div_cnt_ff + 2'b01;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      div_cnt_ff <= 2'b00;
      link_clock_out_ff <= 1'b0;
    end else if (~initiator_enable_ff) begin
      div_cnt_ff <= 2'b00;
      link_clock_out_ff <= 1'b0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      // Divide by one cannot toggle a flop, so it holds high
      link_clock_out_ff <= (clk_div_ff == 2'b00) |
                           (nxt_div_cnt == clk_div_ff); // see R17
    end
  end

  assign o_link_clock_out = link_clock_out_ff;
  assign o_link_tick = initiator_enable_ff &
                       (div_cnt_ff == clk_div_ff);

  // Idle command is all-zero on the used lines; unused lines float
  assign used_mask = width8_ff ? `DLI_WIDE_MASK : `DLI_NARROW_MASK;
  assign o_link_data_lines = 8'h00; // see R17
  assign o_link_data_oe_n = initiator_enable_ff ? ~used_mask :
                            8'hff; // see R17

  // Acknowledge wait supervision
  dli_ack_timer #(
    .LIMIT_W(4)
  ) u_ack_timer (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_tick(o_link_tick),
    .i_start(i_last_xfer),
    .i_ack(i_ack_strobe),
    .i_limit(ack_wait_limit_ff), // see R05
    .o_waiting(timer_waiting),
    .o_expired(expired_pulse)
  );

  assign o_ack_waiting = timer_waiting;
  assign o_wait_expired = expired_pulse;

  // Error events seen by the flags
  assign ack_fault_set = i_ack_strobe &
                         ((i_link_data_in & used_mask) != used_mask);
  assign target_fault_set = i_ack_strobe & i_target_err; // see R13
  // A pending error turns any new request into an idle command
  assign o_txn_cancel = i_txn_request & error_summary_flag_ff; // see R12
  assign o_txn_grant = i_txn_request & ~error_summary_flag_ff &
                       initiator_enable_ff;
  assign cancel_set = o_txn_cancel;
  assign any_error_set = ack_fault_set | cancel_set | expired_pulse |
                         target_fault_set | i_parity_err; // see R09

  // Sticky flags; an event in the clearing cycle keeps its flag set
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      error_summary_flag_ff <= |(`DLI_ERR_STAT_RST & (8'h01 << `DLI_SUM_BIT));
      ack_level_fault_flag_ff <= 1'b0; // see R20
      cancelled_flag_ff <= 1'b0;
      wait_expired_flag_ff <= 1'b0;
      target_fault_flag_ff <= 1'b0;
      parity_fault_flag_ff <= 1'b0;
      received_parity_hi_ff <= 1'b0;
      received_parity_lo_ff <= 1'b0;
    end else begin
      error_summary_flag_ff <= any_error_set |
        (error_summary_flag_ff & ~status_clear); // see R20
      ack_level_fault_flag_ff <= ack_fault_set |
        (ack_level_fault_flag_ff & ~status_clear); // see R11
      cancelled_flag_ff <= cancel_set |
        (cancelled_flag_ff & ~status_clear); // see R12
      wait_expired_flag_ff <= expired_pulse |
        (wait_expired_flag_ff & ~status_clear); // see R04
      target_fault_flag_ff <= target_fault_set |
        (target_fault_flag_ff & ~status_clear); // see R16
      parity_fault_flag_ff <= i_parity_err |
        (parity_fault_flag_ff & ~status_clear); // see R14
      // Parity bits track reception and are not touched by the clear
      if (i_parity_valid) begin
        received_parity_hi_ff <= i_parity_bits[1]; // see R15
        received_parity_lo_ff <= i_parity_bits[0]; // see R15
      end
    end
  end

  // The summary output cannot be masked here
  assign o_error_irq = error_summary_flag_ff; // see R09

  // Pin level follows the target; only the target can drop it
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      ext_irq_flag_ff <= 1'b0;
    end else begin
      ext_irq_flag_ff <= i_ext_irq_pin; // see R18
    end
  end

  assign o_ext_irq = ext_irq_enable_ff & ext_irq_flag_ff; // see R01

  // Read address decode; unmapped words read zero with an error reply
  assign rd_idx = i_s_axi_araddr[IDX_HI:2];
  always @* begin
    rd_val = 8'h00;
    rd_map = 1'b1;
    if (rd_idx == `DLI_IDX_LINK_CTRL) begin
      rd_val = {initiator_enable_ff, width8_ff, 4'h0, clk_div_ff};
    end else if (rd_idx == `DLI_IDX_IRQ_TMO_CTRL) begin
      rd_val = {ext_irq_enable_ff, 3'b000, ack_wait_limit_ff};
    end else if (rd_idx == `DLI_IDX_ERR_STAT) begin
      rd_val = {error_summary_flag_ff, ack_level_fault_flag_ff,
                cancelled_flag_ff, wait_expired_flag_ff,
                target_fault_flag_ff, parity_fault_flag_ff,
                received_parity_hi_ff, received_parity_lo_ff};
    end else if (rd_idx == `DLI_IDX_LINK_STAT) begin
      rd_val = {ext_irq_flag_ff, timer_waiting, 6'h00};
    end else begin
      rd_map = 1'b0;
    end
  end

  // Read channel; data is captured at the address handshake
  assign o_s_axi_arready = ~rvalid_ff;
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `DLI_RESP_OKAY;
    end else if (i_s_axi_arvalid & o_s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h000000, rd_val};
      rresp_ff <= rd_map ? `DLI_RESP_OKAY : `DLI_RESP_SLVERR;
    end else if (rvalid_ff & i_s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign o_s_axi_rvalid = rvalid_ff;
  assign o_s_axi_rdata = rdata_ff;
  assign o_s_axi_rresp = rresp_ff;

endmodule

/* File: logic/dli_consts.vh */
// Register map, field positions and reset values of the link initiator
`ifndef DLI_CONSTS_VH
`define DLI_CONSTS_VH

// Bus address width; each register index is one aligned 32-bit word
`define DLI_AXI_ADDR_W 8
`define DLI_IDX_W 6

// Register indices (byte address is four times the index)
`define DLI_IDX_LINK_CTRL 6'h00
`define DLI_IDX_IRQ_TMO_CTRL 6'h01
`define DLI_IDX_ERR_STAT 6'h02
`define DLI_IDX_LINK_STAT 6'h03

// Link control fields
`define DLI_EN_BIT 7
`define DLI_WIDTH8_BIT 6
`define DLI_DIV_HI 1
`define DLI_DIV_LO 0

// Interrupt enable and acknowledge wait limit fields
`define DLI_IRQ_EN_BIT 7
`define DLI_LIMIT_HI 3
`define DLI_LIMIT_LO 0

// Error status fields
`define DLI_SUM_BIT 7
`define DLI_ACK_FLT_BIT 6
`define DLI_CNCL_BIT 5
`define DLI_WAIT_EXP_BIT 4
`define DLI_TGT_FLT_BIT 3
`define DLI_PAR_FLT_BIT 2
`define DLI_PAR_HI_BIT 1
`define DLI_PAR_LO_BIT 0

// Link status fields
`define DLI_EXT_IRQ_FLAG_BIT 7
`define DLI_WAITING_BIT 6

// Reset values
`define DLI_LINK_CTRL_RST 8'h00
`define DLI_IRQ_TMO_RST 8'h00
`define DLI_ERR_STAT_RST 8'h00

// Data line masks for four- and eight-line operation
`define DLI_NARROW_MASK 8'h0f
`define DLI_WIDE_MASK 8'hff

// Bus responses
`define DLI_RESP_OKAY 2'b00
`define DLI_RESP_SLVERR 2'b10

`endif

/* File: logic/dli_ack_timer.v */
// Acknowledge wait counter measured in link clock cycles
`timescale 1ns/10ps
module dli_ack_timer #(
  parameter LIMIT_W = 4
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_tick,
  input wire i_start,
  input wire i_ack,
  input wire [LIMIT_W-1:0] i_limit,
  output wire o_waiting,
  output wire o_expired
);

  reg armed_ff;
  reg [LIMIT_W-1:0] cnt_ff;
  reg expired_ff;
  reg nxt_armed;
  reg [LIMIT_W-1:0] nxt_cnt;
  reg nxt_expired;

  // Restart wins over everything so a new transaction never inherits time
  always @* begin
    nxt_armed = armed_ff;
    nxt_cnt = cnt_ff;
    nxt_expired = 1'b0;
    if (i_start) begin
      nxt_armed = 1'b1; // see R19
      nxt_cnt = {LIMIT_W{1'b0}};
    end else if (armed_ff) begin
      if (i_ack) begin
        nxt_armed = 1'b0; // see R19
      end else if (i_tick) begin
        // Limit zero expires on the first link cycle without acknowledge
        if (cnt_ff == i_limit) begin
          nxt_armed = 1'b0;
          nxt_expired = 1'b1; // see R03
        end else begin
          nxt_cnt = cnt_ff + {{(LIMIT_W-1){1'b0}}, 1'b1}; // see R06
        end
      end
    end
  end

  // Counter state
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      armed_ff <= 1'b0;
      cnt_ff <= {LIMIT_W{1'b0}};
      expired_ff <= 1'b0;
    end else begin
      armed_ff <= nxt_armed;
      cnt_ff <= nxt_cnt;
      expired_ff <= nxt_expired;
    end
  end

  assign o_waiting = armed_ff;
  assign o_expired = expired_ff;

endmodule

/* File: sim/dli_tgt_model.sv */
// Behavioural model of the far-side target logic on the link
`timescale 1ns/10ps
module dli_tgt_model (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_tick,
  input wire i_go,
  input wire [4:0] i_waits,
  input wire i_bad,
  input wire i_err,
  input wire i_par_err,
  input wire [1:0] i_par,
  output wire o_last_xfer,
  output wire o_ack,
  output wire o_target_err,
  output wire o_parity_err,
  output wire o_parity_valid,
  output wire [1:0] o_parity_bits,
  output wire [7:0] o_data
);
  reg armed_ff;
  reg [4:0] cnt_ff;
  reg [7:0] pat_ff;
  // Ack after the commanded wait; more than the limit only on command
  assign o_ack = armed_ff & i_tick & (cnt_ff == i_waits); // Ack
  assign o_last_xfer = i_go;
  assign o_target_err = o_ack & i_err;
  assign o_parity_err = o_ack & i_par_err;
  assign o_parity_valid = o_ack;
  // Released lines toggle so a stale level never passes for data
  assign o_data = o_ack ? {7'h7f, ~i_bad} : pat_ff;
  assign o_parity_bits = o_ack ? i_par : pat_ff[1:0];
  // Wait count in link cycles and idle pattern
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      armed_ff <= 1'h0;
      cnt_ff <= 5'h00;
      pat_ff <= 8'h5a;
    end else begin
      pat_ff <= ~pat_ff;
      if (i_go) begin
        armed_ff <= 1'h1;
        cnt_ff <= 5'h00;
      end else if (armed_ff & i_tick) begin
        if (o_ack)
          armed_ff <= 1'h0;
        else
          cnt_ff <= cnt_ff + 5'h01;
      end
    end
  end
endmodule

/* File: sim/dli_status_properties.sv */
// Port checks of the link initiator status block
`timescale 1ns/10ps
module dli_status_chk (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_ext_irq_pin,
  input wire o_ext_irq,
  input wire o_error_irq,
  input wire i_txn_request,
  input wire o_txn_grant,
  input wire o_txn_cancel,
  input wire i_last_xfer,
  input wire i_ack_strobe,
  input wire i_target_err,
  input wire i_parity_err,
  input wire [7:0] i_link_data_in,
  input wire [7:0] o_link_data_lines,
  input wire [7:0] o_link_data_oe_n,
  input wire o_link_tick,
  input wire o_ack_waiting,
  input wire o_wait_expired
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  property p_cancel;
    i_txn_request && o_error_irq |-> o_txn_cancel && !o_txn_grant;
  endproperty
  a_cancel: assert property (p_cancel) // Cancel
    else $error("request not cancelled");
  property p_no_cancel;
    !o_error_irq |-> !o_txn_cancel;
  endproperty
  a_no_cancel: assert property (p_no_cancel) // No error
    else $error("cancel without error");
  property p_irq;
    o_ext_irq |-> $past(i_ext_irq_pin);
  endproperty
  a_irq: assert property (p_irq) // Pin follows
    else $error("irq without pin");
  property p_arm;
    i_last_xfer && !i_ack_strobe |=> o_ack_waiting;
  endproperty
  a_arm: assert property (p_arm) // Arm
    else $error("timer not armed");
  property p_stop;
    o_ack_waiting && i_ack_strobe && !i_last_xfer |=> !o_ack_waiting;
  endproperty
  a_stop: assert property (p_stop) // Stop
    else $error("timer not stopped");
  property p_cause;
    $rose(o_wait_expired) |-> $past(o_ack_waiting) && $past(o_link_tick)
      && !$past(i_ack_strobe);
  endproperty
  a_cause: assert property (p_cause) // Tick
    else $error("expiry without tick");
  property p_flag;
    o_wait_expired |=> o_error_irq && !o_wait_expired;
  endproperty
  a_flag: assert property (p_flag) // Flag
    else $error("expiry flag missing");
  property p_ackf;
    i_ack_strobe && i_link_data_in[3:0] != 4'hf |=> o_error_irq;
  endproperty
  a_ackf: assert property (p_ackf) // Low line
    else $error("ack fault missed");
  property p_tgt;
    i_ack_strobe && i_target_err |=> o_error_irq;
  endproperty
  a_tgt: assert property (p_tgt) // Target
    else $error("target fault missed");
  property p_par;
    i_parity_err |=> o_error_irq;
  endproperty
  a_par: assert property (p_par) // Parity
    else $error("parity fault missed");
  property p_idle;
    o_link_tick |-> o_link_data_lines == 8'h00 &&
      o_link_data_oe_n[3:0] == 4'h0;
  endproperty
  a_idle: assert property (p_idle) // Idle
    else $error("data lines not idle");
endmodule
bind dli_status dli_status_chk i_chk (.i_core_clk, .i_reset,
  .i_ext_irq_pin, .o_ext_irq, .o_error_irq, .i_txn_request, .o_txn_grant,
  .o_txn_cancel, .i_last_xfer, .i_ack_strobe, .i_target_err,
  .i_parity_err, .i_link_data_in, .o_link_data_lines, .o_link_data_oe_n,
  .o_link_tick, .o_ack_waiting, .o_wait_expired);

/* File: sim/test_dli_status.sv */
// Self-checking bench for the link initiator status block
`timescale 1ns/10ps
`include "dli_consts.vh"
module test_dli_status;
  localparam [7:0] A_LNK = {`DLI_IDX_LINK_CTRL, 2'h0};
  localparam [7:0] A_CTL = {`DLI_IDX_IRQ_TMO_CTRL, 2'h0};
  localparam [7:0] A_ERR = {`DLI_IDX_ERR_STAT, 2'h0};
  localparam [1:0] OK = `DLI_RESP_OKAY;
  reg clk, rst, awvalid, wvalid, bready, arvalid, rready;
  reg special, pin, req, go, bad, terr, perr;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata;
  reg [4:0] waits;
  reg [1:0] par;
  wire awready, wready, bvalid, arready, rvalid, ext_irq, err_irq, lclk;
  wire grant, cancel, last, ack, t_err, p_err, p_val, tick, waiting, expired;
  wire [1:0] bresp, rresp, p_bits;
  wire [31:0] rdata;
  wire [7:0] din, oe_n;
  integer err_total, checks, exp_seen;
  dli_status i_dut (
    .i_core_clk(clk), .i_reset(rst), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awprot(3'h0), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arprot(3'h0),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_special_mode(special),
    .i_ext_irq_pin(pin), .o_ext_irq(ext_irq), .o_error_irq(err_irq),
    .i_txn_request(req), .o_txn_grant(grant), .o_txn_cancel(cancel),
    .i_last_xfer(last), .i_ack_strobe(ack), .i_target_err(t_err),
    .i_parity_err(p_err), .i_parity_valid(p_val), .i_parity_bits(p_bits),
    .i_link_data_in(din), .o_link_data_lines(), .o_link_data_oe_n(oe_n),
    .o_link_clock_out(lclk), .o_link_tick(tick), .o_ack_waiting(waiting),
    .o_wait_expired(expired));
  dli_tgt_model i_tgt (
    .i_core_clk(clk), .i_reset(rst), .i_tick(tick), .i_go(go),
    .i_waits(waits), .i_bad(bad), .i_err(terr), .i_par_err(perr),
    .i_par(par), .o_last_xfer(last), .o_ack(ack), .o_target_err(t_err),
    .o_parity_err(p_err), .o_parity_valid(p_val), .o_parity_bits(p_bits),
    .o_data(din));
  // 10 MHz clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // Counts expiry pulses, which last one cycle only
  always @(posedge clk) if (expired === 1'h1) exp_seen <= exp_seen + 1;
  // A hang ends the run as a failure
  initial begin
    repeat (5000) @(posedge clk);
    err_total = err_total + 1;
    tally_and_finish;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Handshakes are judged at the falling edge, where they are settled
  task wr(input [7:0] a, input [7:0] d, input [1:0] er);
    reg ha, hw, hb;
    begin
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      hb = 1'h0;
      while (!hb) begin
        @(negedge clk);
        ha = awvalid && awready;
        hw = wvalid && wready;
        hb = !awvalid && !wvalid && bvalid;
        @(posedge clk);
        if (ha) awvalid <= 1'h0;
        if (hw) wvalid <= 1'h0;
      end
      bready <= 1'h0;
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge clk);
    end
  endtask
  task rd(input [7:0] a, input [7:0] e, input [1:0] er);
    reg ha, hr;
    reg [31:0] v;
    reg [1:0] s;
    begin
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      hr = 1'h0;
      while (!hr) begin
        @(negedge clk);
        ha = arvalid && arready;
        hr = !arvalid && rvalid;
        v = rdata;
        s = rresp;
        @(posedge clk);
        if (ha) arvalid <= 1'h0;
      end
      rready <= 1'h0;
      chk(v, {24'h0, e});
      chk({30'h0, s}, {30'h0, er});
      @(posedge clk);
    end
  endtask
  // One link transaction; returns once the target has acknowledged
  task txn(input [4:0] w, input b, input te, input pe, input [1:0] p);
    begin
      waits <= w;
      bad <= b;
      terr <= te;
      perr <= pe;
      par <= p;
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
      do @(negedge clk); while (ack !== 1'h1);
      repeat (3) @(posedge clk);
    end
  endtask
  task t_reset;
    begin
      rd(A_ERR, 8'h00, OK); // Status clear
      rd(A_CTL, 8'h00, OK); // Control clear
      chk({23'h0, lclk, oe_n}, 32'hff); // Lines released
    end
  endtask
  task t_ctrl;
    begin
      wr(A_CTL, 8'h83, OK); // Bits 6:4 zero
      rd(A_CTL, 8'h83, OK); // Limit stored
      pin <= 1'h1;
      repeat (2) @(posedge clk);
      chk({31'h0, ext_irq}, 32'h1); // Enabled
      rd(8'h0c, 8'h80, OK); // Pin level flag
      wr(A_CTL, 8'h03, OK);
      chk({31'h0, ext_irq}, 32'h0); // Blocked
      rd(8'h10, 8'h00, `DLI_RESP_SLVERR);
      wr(8'h10, 8'hff, `DLI_RESP_SLVERR);
    end
  endtask
  task t_once;
    reg c;
    begin
      wr(A_LNK, 8'h81, OK);
      // Divide by two: the link clock flips every bus cycle
      @(negedge clk);
      c = lclk;
      @(negedge clk);
      chk({23'h0, c ^ lclk, oe_n}, 32'h1f0); // Clock and idle
      @(posedge clk);
      wr(A_LNK, 8'h40, OK);
      rd(A_LNK, 8'h81, OK); // Setup locked
      wr(A_CTL, 8'h8f, OK);
      rd(A_CTL, 8'h83, OK); // Limit kept
      special <= 1'h1;
      wr(A_CTL, 8'h00, OK);
      rd(A_CTL, 8'h00, OK); // Free in special mode
      wr(A_CTL, 8'h03, OK);
      special <= 1'h0;
    end
  endtask
  task t_wait;
    begin
      txn(5'h03, 1'h0, 1'h0, 1'h0, 2'h0);
      rd(A_ERR, 8'h00, OK); // Wait at limit
      txn(5'h04, 1'h0, 1'h0, 1'h0, 2'h0);
      chk(exp_seen, 32'h1); // One expiry
      rd(A_ERR, 8'h90, OK); // Expiry flag
      wr(A_ERR, 8'h00, OK);
      rd(A_ERR, 8'h90, OK); // Zero kept
      wr(A_ERR, 8'h80, OK);
      rd(A_ERR, 8'h00, OK); // Cleared
      special <= 1'h1;
      wr(A_CTL, 8'h00, OK);
      special <= 1'h0;
      txn(5'h00, 1'h0, 1'h0, 1'h0, 2'h0);
      rd(A_ERR, 8'h00, OK); // No wait
      txn(5'h01, 1'h0, 1'h0, 1'h0, 2'h0);
      rd(A_ERR, 8'h90, OK); // One wait too many
      wr(A_ERR, 8'h80, OK);
    end
  endtask
  task t_fault(input b, input te, input pe, input [7:0] e);
    begin
      txn(5'h00, b, te, pe, 2'h2);
      rd(A_ERR, e, OK); // Fault flags
      wr(A_ERR, 8'h80, OK);
      rd(A_ERR, 8'h02, OK); // Parity bits kept
    end
  endtask
  task t_cancel;
    begin
      txn(5'h00, 1'h0, 1'h1, 1'h0, 2'h1);
      req <= 1'h1;
      @(negedge clk);
      chk({30'h0, cancel, grant}, 32'h2); // Cancelled
      @(posedge clk);
      req <= 1'h0;
      rd(A_ERR, 8'ha9, OK); // Cancel flag
      wr(A_ERR, 8'h80, OK);
      req <= 1'h1;
      @(negedge clk);
      chk({30'h0, cancel, grant}, 32'h1); // Granted
      @(posedge clk);
      req <= 1'h0;
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {special, pin, req, go, bad, terr, perr} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    waits = 5'h00;
    par = 2'h0;
    err_total = 0;
    checks = 0;
    exp_seen = 0;
    rst = 1'h1;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset;
    t_ctrl;
    t_once;
    t_wait;
    t_fault(1'h1, 1'h0, 1'h0, 8'hc2); // Low line
    t_fault(1'h0, 1'h1, 1'h0, 8'h8a); // Target error
    t_fault(1'h0, 1'h0, 1'h1, 8'h86); // Parity error
    t_cancel;
    tally_and_finish;
  end
endmodule
